// ==== common/aau_consts.svh ====
// Constants of the accumulator add unit: opcode patterns, limits, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef AAU_CONSTS_SVH
`define AAU_CONSTS_SVH

// Instruction patterns, compared under their masks; the ABS pattern is compared whole.
`define AAU_OP_ADD_MASK 16'hF000
`define AAU_OP_ADD_VAL 16'h0000
`define AAU_OP_ADD_WITH_CARRY_MASK 16'hFF00
`define AAU_OP_ADD_WITH_CARRY_VAL 16'h4300
`define AAU_OP_ADD_SHORT_IMMEDIATE_MASK 16'hFF00
`define AAU_OP_ADD_SHORT_IMMEDIATE_VAL 16'hCC00
`define AAU_OP_ABS_VAL 16'hCE1B
`define AAU_SHIFT_LSB 8
`define AAU_SHIFT_W 4
`define AAU_ACC_MAX 32'h7FFF_FFFF
`define AAU_ACC_MIN 32'h8000_0000
`define AAU_ACC_RST 32'h0000_0000
`define AAU_PC_RST 16'h0000
// Register offsets on the bus (word addresses).
`define AAU_REG_CTRL 4'h0
`define AAU_REG_ACC 4'h1
`define AAU_REG_STAT 4'h2
`define AAU_REG_MASK 4'h3
`define AAU_REG_PC 4'h4
`define AAU_REG_EVT 4'h5
// Control bit positions.
`define AAU_CTRL_SXM 0
`define AAU_CTRL_OVM 1
`define AAU_CTRL_C 2
`define AAU_CTRL_OV 3
// Event bit positions.
`define AAU_EVT_OV 0
`define AAU_EVT_CARRY 1
`define AAU_EVT_DONE 2
`define AAU_EVT_W 3
// Cycles an instruction spends when not repeated.
`define AAU_FIRST_CYCLES 2'd2
`endif

// ==== common/aau_pkg.sv ====
// Types shared by the accumulator add unit.
// Assumes the constants header sits alongside.
`include "aau_consts.svh"
package aau_pkg;
    typedef enum logic [2:0] {
        AAU_IDLE = 3'b001,
        AAU_FETCH = 3'b010,
        AAU_EXEC = 3'b100
    } aau_state_t;

    typedef enum logic [3:0] {
        AAU_K_ADD = 4'b0001,
        AAU_K_ADD_WITH_CARRY = 4'b0010,
        AAU_K_ADD_SHORT_IMMEDIATE = 4'b0100,
        AAU_K_ABS = 4'b1000
    } aau_kind_t;
endpackage : aau_pkg

// ==== logic/aau_core.sv ====
// Accumulator add datapath with an Avalon-MM register port.
// Assumes one 100 MHz clock; the data word and instruction are
// presented by the fetch logic together with i_issue.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "aau_consts.svh"

module aau_core
    import aau_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_issue,
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_data,
    input wire logic i_repeat,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_busy,
    output logic o_done,
    output logic [31:0] o_acc,
    output logic o_carry,
    output logic o_overflow_flag,
    output logic [15:0] o_program_counter,
    output logic o_irq
);
    // -----------------------------------------------------------------
    // Decode and operand formation
    // -----------------------------------------------------------------
    aau_state_t state;
    aau_kind_t kind;
    logic [15:0] instr;
    logic [15:0] data;
    logic rep;
    logic [31:0] acc;
    logic carry;
    logic overflow_flag;
    logic sign_extend_mode;
    logic overflow_mode;
    logic [15:0] program_counter;
    logic [`AAU_EVT_W-1:0] evt_stat;
    logic [`AAU_EVT_W-1:0] evt_mask;
    logic bus_ack;
    logic cpu_flag_wr;

    aau_kind_t next_kind;
    logic legal;
    always_comb begin
        next_kind = AAU_K_ADD;
        legal = 1'b1;
        if ((i_instr & `AAU_OP_ADD_MASK) == `AAU_OP_ADD_VAL) begin
            next_kind = AAU_K_ADD;
        end else if ((i_instr & `AAU_OP_ADD_WITH_CARRY_MASK) == `AAU_OP_ADD_WITH_CARRY_VAL) begin
            next_kind = AAU_K_ADD_WITH_CARRY;
        end else if ((i_instr & `AAU_OP_ADD_SHORT_IMMEDIATE_MASK) == `AAU_OP_ADD_SHORT_IMMEDIATE_VAL) begin
            next_kind = AAU_K_ADD_SHORT_IMMEDIATE;
        end else if (i_instr == `AAU_OP_ABS_VAL) begin
            next_kind = AAU_K_ABS;
        end else begin
            legal = 1'b0;
        end
    end

    logic [3:0] shift;
    logic [31:0] mem_ext;
    logic [31:0] operand;
    logic cin;
    assign shift = instr[`AAU_SHIFT_LSB +: `AAU_SHIFT_W];
    // The operand is widened first so that shifted-out high bits stay
    // inside the 32-bit sum.
    assign mem_ext = sign_extend_mode ? {{16{data[15]}}, data}
                                      : {16'h0000, data};
    always_comb begin
        operand = 32'h0000_0000;
        cin = 1'b0;
        unique case (kind)
            AAU_K_ADD: operand = mem_ext << shift;
            AAU_K_ADD_WITH_CARRY: begin
                operand = {16'h0000, data};
                cin = carry;
            end
            AAU_K_ADD_SHORT_IMMEDIATE: operand = {24'h00_0000, instr[7:0]};
            AAU_K_ABS: operand = 32'h0000_0000;
        endcase
    end

    // -----------------------------------------------------------------
    // Arithmetic
    // -----------------------------------------------------------------
    logic [32:0] sum;
    logic add_ovf;
    logic [31:0] add_res;
    logic [31:0] abs_res;
    logic abs_ovf;
    assign sum = {1'b0, acc} + {1'b0, operand} + {32'h0000_0000, cin};
    assign add_ovf = (acc[31] == operand[31]) && (sum[31] != acc[31]);
    always_comb begin
        add_res = sum[31:0];
        if (add_ovf && overflow_mode) begin
            add_res = acc[31] ? `AAU_ACC_MIN : `AAU_ACC_MAX;
        end
    end
    assign abs_ovf = (acc == `AAU_ACC_MIN);
    always_comb begin
        abs_res = acc;
        if (acc[31]) begin
            abs_res = 32'h0000_0000 - acc;
        end
        if (abs_ovf && overflow_mode) begin
            abs_res = `AAU_ACC_MAX;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer: fetch cycle then execute; repeats skip the fetch.
    // -----------------------------------------------------------------
    logic exec;
    assign exec = (state == AAU_EXEC);
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= AAU_IDLE;
            kind <= AAU_K_ADD;
            instr <= 16'h0000;
            data <= 16'h0000;
            rep <= 1'b0;
        end else begin
            unique case (state)
                AAU_IDLE, AAU_EXEC: begin
                    if (i_issue && legal) begin
                        kind <= next_kind;
                        instr <= i_instr;
                        data <= i_data;
                        rep <= i_repeat;
                        // A repeated issue in execute, following a repeated one, goes straight to execute.
                        state <= (i_repeat && rep && exec) ? AAU_EXEC
                                                          : AAU_FETCH;
                    end else begin
                        state <= AAU_IDLE;
                    end
                end
                AAU_FETCH: state <= AAU_EXEC;
                default: state <= AAU_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Architectural state
    // -----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc <= `AAU_ACC_RST;
            program_counter <= `AAU_PC_RST;
        end else if (exec) begin
            acc <= (kind == AAU_K_ABS) ? abs_res : add_res;
            program_counter <= program_counter + 16'h0001;
        end else if (bus_ack && i_avs_write
                     && i_avs_address == `AAU_REG_ACC) begin
            acc <= i_avs_writedata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carry <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (exec) begin
            if (kind == AAU_K_ABS) begin
                carry <= 1'b0;
                overflow_flag <= overflow_flag | abs_ovf;
            end else begin
                carry <= sum[32];
                overflow_flag <= overflow_flag | add_ovf;
            end
        end else if (cpu_flag_wr) begin
            carry <= i_avs_writedata[`AAU_CTRL_C];
            overflow_flag <= i_avs_writedata[`AAU_CTRL_OV];
        end
    end

    // -----------------------------------------------------------------
    // Register port and interrupt
    // -----------------------------------------------------------------
    logic [`AAU_EVT_W-1:0] evt_set;
    assign evt_set = {exec, exec && kind != AAU_K_ABS && sum[32],
                      exec && (kind == AAU_K_ABS ? abs_ovf : add_ovf)};
    // One wait cycle per access; the ack edge is the only one with effect.
    assign cpu_flag_wr = bus_ack && i_avs_write
                         && i_avs_address == `AAU_REG_CTRL;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (i_avs_read || i_avs_write) && !bus_ack;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sign_extend_mode <= 1'b0;
            overflow_mode <= 1'b0;
            evt_mask <= '0;
        end else if (bus_ack && i_avs_write) begin
            if (i_avs_address == `AAU_REG_CTRL) begin
                sign_extend_mode <= i_avs_writedata[`AAU_CTRL_SXM];
                overflow_mode <= i_avs_writedata[`AAU_CTRL_OVM];
            end
            if (i_avs_address == `AAU_REG_MASK) begin
                evt_mask <= i_avs_writedata[`AAU_EVT_W-1:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `AAU_EVT_W; gi++) begin : g_evt
            // A new event wins over a write-one clear in the same cycle.
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    evt_stat[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    evt_stat[gi] <= 1'b1;
                end else if (bus_ack && i_avs_write
                             && i_avs_address == `AAU_REG_STAT
                             && i_avs_writedata[gi]) begin
                    evt_stat[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (i_avs_address)
            `AAU_REG_CTRL: begin
                next_rdata[`AAU_CTRL_SXM] = sign_extend_mode;
                next_rdata[`AAU_CTRL_OVM] = overflow_mode;
                next_rdata[`AAU_CTRL_C] = carry;
                next_rdata[`AAU_CTRL_OV] = overflow_flag;
            end
            `AAU_REG_ACC: next_rdata = acc;
            `AAU_REG_STAT: next_rdata[`AAU_EVT_W-1:0] = evt_stat;
            `AAU_REG_MASK: next_rdata[`AAU_EVT_W-1:0] = evt_mask;
            `AAU_REG_PC: next_rdata[15:0] = program_counter;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_waitrequest <= 1'b1;
            o_irq <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_acc <= `AAU_ACC_RST;
            o_carry <= 1'b0;
            o_overflow_flag <= 1'b0;
            o_program_counter <= `AAU_PC_RST;
        end else begin
            o_avs_readdata <= next_rdata;
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !bus_ack);
            o_irq <= |(evt_stat & evt_mask);
            o_busy <= (state != AAU_IDLE);
            o_done <= exec;
            o_acc <= acc;
            o_carry <= carry;
            o_overflow_flag <= overflow_flag;
            o_program_counter <= program_counter;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    shift_add_a: assert property (
        exec && kind == AAU_K_ADD && !overflow_mode
        |=> acc == $past(acc) + ($past(mem_ext) << $past(shift)))
        else $error("shifted add result wrong");
    sign_ext_a: assert property (
        exec && kind == AAU_K_ADD
        |-> mem_ext[31:16] == {16{sign_extend_mode & data[15]}})
        else $error("memory operand extension wrong");
    carry_upd_a: assert property (
        exec && kind != AAU_K_ABS |=> carry == $past(sum[32]))
        else $error("carry not updated");
    add_with_carry_sum_a: assert property (
        exec && kind == AAU_K_ADD_WITH_CARRY && !overflow_mode
        |=> acc == $past(acc) + {16'h0000, $past(data)}
                   + {31'h0, $past(carry)})
        else $error("add with carry wrong");
    add_with_carry_carry_a: assert property (
        exec && kind == AAU_K_ADD_WITH_CARRY |=> carry == $past(sum[32]))
        else $error("add with carry flag wrong");
    add_short_immediate_zero_a: assert property (
        exec && kind == AAU_K_ADD_SHORT_IMMEDIATE |-> operand[31:8] == 24'h00_0000)
        else $error("short immediate not zero extended");
    add_short_immediate_sum_a: assert property (
        exec && kind == AAU_K_ADD_SHORT_IMMEDIATE && !overflow_mode
        |=> acc == $past(acc) + ({16'h0000, $past(instr)} & 32'h0000_00FF))
        else $error("short immediate add wrong");
    abs_min_a: assert property (
        exec && kind == AAU_K_ABS && acc == `AAU_ACC_MIN |=> overflow_flag)
        else $error("abs overflow not flagged");
    abs_neg_a: assert property (
        exec && kind == AAU_K_ABS && acc[31] && acc != `AAU_ACC_MIN
        |=> acc == 32'h0000_0000 - $past(acc))
        else $error("negative accumulator not negated");
    abs_pos_a: assert property (
        exec && kind == AAU_K_ABS && !acc[31] |=> acc == $past(acc))
        else $error("non-negative accumulator changed");
    repeat_one_a: assert property (
        exec && rep && i_issue && legal && i_repeat |=> exec)
        else $error("repeat took more than one cycle");
    saturate_a: assert property (
        exec && kind != AAU_K_ABS && add_ovf && overflow_mode
        |=> acc == `AAU_ACC_MAX || acc == `AAU_ACC_MIN)
        else $error("no saturation");
    pc_step_a: assert property (
        exec |=> program_counter == $past(program_counter) + 16'h0001)
        else $error("program counter step wrong");

    cov_repeat_c: cover property (exec ##1 exec);
    cov_sat_c: cover property (exec && add_ovf && overflow_mode);
    cov_abs_c: cover property (exec && kind == AAU_K_ABS && acc[31]);
    cov_add_with_carry_c: cover property (exec && kind == AAU_K_ADD_WITH_CARRY && carry);
    cov_irq_c: cover property (o_irq);
endmodule : aau_core

// ==== bench/aau_tb.sv ====
// Self-checking bench for the accumulator add unit.
// Assumes the design package and the constants header are on the path.
`timescale 1ns/1ps
`include "aau_consts.svh"
module tb;
    import aau_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic issue = 0;
    logic repeat_from_mem = 0;
    logic rd = 0;
    logic wr = 0;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, acc, r;
    logic [15:0] instr, data, pc;
    logic wait_req, busy, done, carry, ovf, irq;
    logic [31:0] m_acc;
    logic m_c, m_ov, m_sxm, m_ovm;
    logic [15:0] m_pc;
    logic [49:0] eq[$];
    logic [31:0] rq[$];
    logic [49:0] e;
    integer seed = 32'hc547_202c;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;

    aau_core u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_issue(issue),
        .i_instr(instr), .i_data(data), .i_repeat(repeat_from_mem),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .o_busy(busy), .o_done(done),
        .o_acc(acc), .o_carry(carry), .o_overflow_flag(ovf),
        .o_program_counter(pc), .o_irq(irq));

    always #5 clk = ~clk;

    task check(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : check

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always @(posedge clk) begin
        if (rd && wait_req === 1'b0) begin
            check("readdata", rq.pop_front(), rdata);
        end
    end

    // The registered copies trail o_done by one cycle; the monitor never
    // blocks, so back-to-back repetitions are all seen.
    logic done_d = 0;
    always @(posedge clk) begin
        if (done === 1'b1) begin
            check("busy", 32'h0000_0001, {31'h0, busy});
        end
        if (done_d) begin
            e = eq.pop_front();
            check("acc", e[31:0], acc);
            check("carry", {31'h0, e[32]}, {31'h0, carry});
            check("ovflag", {31'h0, e[33]}, {31'h0, ovf});
            check("pc", {16'h0, e[49:34]}, {16'h0, pc});
        end
        done_d <= (done === 1'b1);
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        wr <= 0;
        rd <= 0;
    endtask : bus

    task rdchk(input logic [3:0] a, input logic [31:0] x);
        rq.push_back(x);
        bus(0, a, 32'h0000_0000);
    endtask : rdchk

    task set_ctrl(input logic sx, input logic om, input logic c);
        m_sxm = sx;
        m_ovm = om;
        m_c = c;
        m_ov = 0;
        bus(1, `AAU_REG_CTRL, {28'h000_0000, 1'b0, c, om, sx});
    endtask : set_ctrl

    task set_acc(input logic [31:0] v);
        m_acc = v;
        bus(1, `AAU_REG_ACC, v);
    endtask : set_acc

    task model(input logic [15:0] ins, input logic [15:0] d);
        logic [31:0] op;
        logic [32:0] s;
        logic v, wc;
        wc = ins[15:8] == 8'h43;
        if (ins == `AAU_OP_ABS_VAL) begin
            m_c = 0;
            if (m_acc == `AAU_ACC_MIN) begin
                m_ov = 1;
                m_acc = m_ovm ? `AAU_ACC_MAX : m_acc;
            end else if (m_acc[31]) m_acc = -m_acc;
        end else begin
            if (ins[15:8] == 8'hCC) op = {24'h00_0000, ins[7:0]};
            else if (wc) op = {16'h0000, d};
            else op = (m_sxm ? {{16{d[15]}}, d} : {16'h0000, d})
                << ins[11:8];
            s = {1'b0, m_acc} + {1'b0, op} + {32'h0, wc & m_c};
            v = m_acc[31] == op[31] && s[31] != m_acc[31];
            m_c = s[32];
            m_ov = m_ov | v;
            m_acc = (v && m_ovm) ? (m_acc[31] ? `AAU_ACC_MIN : `AAU_ACC_MAX)
                : s[31:0];
        end
        m_pc = m_pc + 16'h0001;
        eq.push_back({m_pc, m_ov, m_c, m_acc});
    endtask : model

    task run(input logic [15:0] ins, input logic [15:0] d);
        model(ins, d);
        @(posedge clk);
        issue <= 1;
        instr <= ins;
        data <= d;
        @(posedge clk);
        issue <= 0;
        while (done !== 1'b1) @(posedge clk);
        repeat (4) @(posedge clk);
        check("busy", 32'h0000_0000, {31'h0, busy});
    endtask : run

    // Three repetitions: only the first may spend a fetch cycle, so the
    // done pulses must follow one another with no gap.
    task run_rep(input logic [15:0] ins, input logic [47:0] ds);
        for (int i = 0; i < 3; i++) model(ins, ds[16*i +: 16]);
        @(posedge clk);
        issue <= 1;
        repeat_from_mem <= 1;
        instr <= ins;
        data <= ds[15:0];
        @(posedge clk);
        issue <= 0;
        @(posedge clk);
        issue <= 1;
        data <= ds[31:16];
        @(posedge clk);
        data <= ds[47:32];
        @(posedge clk);
        issue <= 0;
        repeat_from_mem <= 0;
        repeat (2) begin
            @(posedge clk);
            check("repeat done", 32'h0000_0001, {31'h0, done});
        end
        repeat (4) @(posedge clk);
        check("busy", 32'h0000_0000, {31'h0, busy});
    endtask : run_rep

    initial begin
        addr = 0;
        wdata = 0;
        instr = 0;
        data = 0;
        m_acc = 0;
        m_c = 0;
        m_ov = 0;
        m_sxm = 0;
        m_ovm = 0;
        m_pc = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        // An undefined opcode must be dropped without starting the sequencer.
        @(posedge clk);
        issue <= 1;
        instr <= 16'h5500;
        @(posedge clk);
        issue <= 0;
        repeat (2) @(posedge clk);
        check("busy", 32'h0000_0000, {31'h0, busy});
        rdchk(`AAU_REG_CTRL, 32'h0000_0000);
        rdchk(`AAU_REG_ACC, 32'h0000_0000);
        rdchk(`AAU_REG_PC, 32'h0000_0000);
        bus(1, 4'h7, 32'hFFFF_FFFF);
        rdchk(4'h7, 32'h0000_0000);
        $display("test reset and map done");
        for (int m = 0; m < 4; m++) begin
            r = $random(seed);
            set_ctrl(m[0], m[1], 1);
            set_acc(32'hFFFF_FFFF);
            run(16'h4301, 16'h0000);
            run(16'h4302, r[15:0]);
            run(16'hCCFF, 16'hFFFF);
            for (int k = 0; k < 4; k++) begin
                r = $random(seed);
                run({4'h0, r[11:8], 1'b0, r[6:0]}, r[31:16]);
            end
            r = $random(seed);
            run_rep({4'h0, r[27:24], 8'h10},
                {r[15:0], r[31:16], r[23:8]});
            set_acc(32'h7FFF_FFF0);
            run(16'h0F01, 16'h7FFF);
            set_acc(`AAU_ACC_MIN);
            run(16'h0F01, 16'h8000);
            set_acc(`AAU_ACC_MIN);
            run(`AAU_OP_ABS_VAL, 16'h0000);
            set_acc($random(seed));
            run(`AAU_OP_ABS_VAL, 16'h0000);
            rdchk(`AAU_REG_CTRL, {28'h000_0000, m_ov, m_c, m_ovm, m_sxm});
            rdchk(`AAU_REG_ACC, m_acc);
            $display("test modes %0d done", m);
        end
        set_acc(32'h0000_0000);
        bus(1, `AAU_REG_STAT, 32'h0000_0007);
        bus(1, `AAU_REG_MASK, 32'h0000_0004);
        run(16'hCC01, 16'h0000);
        check("irq", 32'h0000_0001, {31'h0, irq});
        rdchk(`AAU_REG_STAT, 32'h0000_0004);
        bus(1, `AAU_REG_STAT, 32'h0000_0004);
        repeat (3) @(posedge clk);
        check("irq", 32'h0000_0000, {31'h0, irq});
        bus(1, `AAU_REG_MASK, 32'h0000_0000);
        run(16'hCC01, 16'h0000);
        check("irq", 32'h0000_0000, {31'h0, irq});
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule : tb
